// ### common/fps_pkg.sv
// constants and state type for the fan pwm fault supervisor
package fps_pkg;

    // ****************************************
    // level codes, 10 mV per step
    // ****************************************
    localparam int          LVL_W           = 9;
    localparam logic [8:0]  RAMP_FLOOR      = 9'h078;
    localparam logic [8:0]  RAMP_CEILING    = 9'h104;
    localparam logic [8:0]  RAMP_SPAN       = RAMP_CEILING - RAMP_FLOOR;
    localparam logic [8:0]  OVERHEAT_OFFSET = 9'h002;
    localparam logic [8:0]  OVERHEAT_HYST   = 9'h008;
    localparam logic [8:0]  OVERHEAT_THR    = RAMP_CEILING + OVERHEAT_OFFSET;
    localparam logic [8:0]  OVERHEAT_REL    = OVERHEAT_THR - OVERHEAT_HYST;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_FREQ_HZ       = 100_000_000;
    localparam int CLK_PERIOD_NS     = 10;
    localparam int PWM_FREQ_HZ       = 30;
    localparam int PWM_PERIOD_CYCLES = CLK_FREQ_HZ / PWM_FREQ_HZ;
    // longest step time: rounds down
    localparam int RAMP_STEP_CYCLES  = PWM_PERIOD_CYCLES / int'(RAMP_SPAN);
    localparam int BLANK_TIME_NS     = 20_000;
    // least blanking time: rounds up
    localparam int BLANK_CYCLES      = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // supervisor counts, in pwm cycles except the fault-clear pulse count
    // ****************************************
    localparam logic [5:0] MISS_LIMIT         = 6'h20;
    localparam logic [5:0] DIAG_LEN           = 6'h03;
    localparam logic [5:0] STARTUP_LEN        = 6'h20;
    localparam logic [4:0] FAULT_WINDOW_LEN   = 5'h1f;
    localparam logic [4:0] FAULT_CLEAR_PULSES = 5'h10;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_STARTUP,
        ST_RUN,
        ST_DIAG,
        ST_FAULT
    } fps_state_t;

endpackage

// ### core/fps_fan_pwm_fault_supervisor.sv
// fan pwm generator with missing-pulse fault supervisor
`timescale 1ns/1ns

// Function
// - PWM period comes from a ramp counter sweeping floor to ceiling, 30 Hz nominal.
// - PWM is high while the controlling level exceeds the ramp.
// - Duty equals (level minus floor) times 100 over the ramp span.
// - Controlling level is the larger of temperature and minimum-speed levels.
// - Minimum-speed below off threshold enters shutdown: PWM low, alarm released.
// - In shutdown the PWM output is actively driven low.
// - Minimum-speed above wake threshold after shutdown starts full power-up sequence.
// - Overheat variant: alarm asserts when temperature reaches ceiling plus 20 mV.
// - Overheat alarm releases once temperature drops more than 80 mV below threshold, or on shutdown or overheat disable.
// - No fan pulse for 32 PWM cycles starts a 3-cycle full-on diagnostic.
// - A pulse during the diagnostic returns to normal PWM without fault.
// - Diagnostic without pulse starts a 32-cycle full-on start-up interval.
// - Pulses in start-up resume PWM; otherwise fan fault, alarm low.
// - During fan fault: alarm low, PWM continuously high, pulses still counted.
// - Fault clears after 16 pulses within a 32-cycle window; PWM resumes.
// - Shutdown during fault releases alarm and forces PWM low; wake restarts.
// - Fault forces 100% duty regardless of levels; recovery follows controlling level.
// - Alarm is active-low open drain; the system supplies the pull-up.
// - Power-up or wake drives 32 full-on cycles, repeated once before fault.
// - Every detected fan pulse clears the missing-pulse counter.
// - Fan pulses are ignored during blanking after each PWM turn-on.
module fps_fan_pwm_fault_supervisor #(
    parameter int STEP_CYCLES = fps_pkg::RAMP_STEP_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [8:0] tempLevel,
    input  wire logic [8:0] minSpeedLevel,
    input  wire logic [8:0] offThreshold,
    input  wire logic [8:0] wakeThreshold,
    input  wire logic       overheatEnable,
    input  wire logic       fanPulse,
    input  wire logic       faultIn,
    output logic            pwmOut,
    output logic            faultOut,
    output logic            faultOe
);

    // ****************************************
    // declarations
    // ****************************************
    fps_pkg::fps_state_t state;
    fps_pkg::fps_state_t next_state;
    logic [15:0]         stepCnt;
    logic [8:0]          ramp;
    logic                cycleTick;
    logic [8:0]          ctrlLevel;
    logic                offReq;
    logic                wakeReq;
    logic [10:0]         blankCnt;
    logic                pulseOk;
    logic [5:0]          cycCnt;
    logic                retried;
    logic [5:0]          missCnt;
    logic [4:0]          winCyc;
    logic [4:0]          winCnt;
    logic                overheat;
    logic                next_pwm;

    function automatic logic [8:0] larger(input logic [8:0] a, input logic [8:0] b);
        larger = (a > b) ? a : b;
    endfunction

    // ****************************************
    // ramp and cycle tick
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stepCnt   <= 16'h0000;
            ramp      <= fps_pkg::RAMP_FLOOR;
            cycleTick <= 1'b0;
        end else begin
            cycleTick <= 1'b0;
            if (stepCnt == 16'(STEP_CYCLES - 1)) begin
                stepCnt <= 16'h0000;
                // ramp visits span values so a ceiling level is always above it
                if (ramp == fps_pkg::RAMP_CEILING - 9'h001) begin
                    ramp      <= fps_pkg::RAMP_FLOOR;
                    cycleTick <= 1'b1;
                end else begin
                    ramp <= ramp + 9'h001;
                end
            end else begin
                stepCnt <= stepCnt + 16'h0001;
            end
        end
    end

    assign ctrlLevel = larger(tempLevel, minSpeedLevel);
    assign offReq    = minSpeedLevel < offThreshold;
    assign wakeReq   = minSpeedLevel > wakeThreshold;
    assign pulseOk   = fanPulse && (blankCnt == 11'h000);

    // ****************************************
    // turn-on blanking
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            blankCnt <= 11'h000;
        end else if (next_pwm && !pwmOut) begin
            // drive turn-on kicks the sense current, looks like a pulse
            blankCnt <= 11'(fps_pkg::BLANK_CYCLES);
        end else if (blankCnt != 11'h000) begin
            blankCnt <= blankCnt - 11'h001;
        end
    end

    // ****************************************
    // supervisor state machine
    // ****************************************
    always_comb begin
        next_state = state;
        unique case (state)
            fps_pkg::ST_OFF: begin
                if (wakeReq) begin
                    next_state = fps_pkg::ST_STARTUP;
                end
            end
            fps_pkg::ST_STARTUP: begin
                if (pulseOk) begin
                    next_state = fps_pkg::ST_RUN;
                end else if (cycleTick && cycCnt == fps_pkg::STARTUP_LEN - 6'h01 && retried) begin
                    next_state = fps_pkg::ST_FAULT;
                end
            end
            fps_pkg::ST_RUN: begin
                if (!pulseOk && cycleTick && missCnt == fps_pkg::MISS_LIMIT - 6'h01) begin
                    next_state = fps_pkg::ST_DIAG;
                end
            end
            fps_pkg::ST_DIAG: begin
                if (pulseOk) begin
                    next_state = fps_pkg::ST_RUN;
                end else if (cycleTick && cycCnt == fps_pkg::DIAG_LEN - 6'h01) begin
                    next_state = fps_pkg::ST_STARTUP;
                end
            end
            fps_pkg::ST_FAULT: begin
                if (winCnt == fps_pkg::FAULT_CLEAR_PULSES) begin
                    next_state = fps_pkg::ST_RUN;
                end
            end
        endcase
        if (offReq) begin
            next_state = fps_pkg::ST_OFF;
        end
    end

    // leaving reset counts as power-up: start-up with one retry
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= fps_pkg::ST_STARTUP;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // interval counters
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cycCnt <= 6'h00;
        end else if (state != next_state) begin
            cycCnt <= 6'h00;
        end else if (cycleTick) begin
            if (state == fps_pkg::ST_STARTUP && cycCnt == fps_pkg::STARTUP_LEN - 6'h01) begin
                cycCnt <= 6'h00;
            end else begin
                cycCnt <= cycCnt + 6'h01;
            end
        end
    end

    // diagnostic path skips the power-up retry
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            retried <= 1'b0;
        end else if (state == fps_pkg::ST_OFF) begin
            retried <= 1'b0;
        end else if (state == fps_pkg::ST_DIAG) begin
            retried <= 1'b1;
        end else if (state == fps_pkg::ST_STARTUP && cycleTick && cycCnt == fps_pkg::STARTUP_LEN - 6'h01) begin
            retried <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            missCnt <= 6'h00;
        end else if (state != fps_pkg::ST_RUN || pulseOk) begin
            missCnt <= 6'h00;
        end else if (cycleTick) begin
            missCnt <= missCnt + 6'h01;
        end
    end

    // fixed 32-cycle windows; a burst spanning a boundary must reach 16 again
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            winCyc <= 5'h00;
            winCnt <= 5'h00;
        end else if (state != fps_pkg::ST_FAULT) begin
            winCyc <= 5'h00;
            winCnt <= 5'h00;
        end else if (cycleTick && winCyc == fps_pkg::FAULT_WINDOW_LEN) begin
            winCyc <= 5'h00;
            winCnt <= 5'h00;
        end else begin
            winCyc <= winCyc + 5'(cycleTick);
            winCnt <= winCnt + 5'(pulseOk);
        end
    end

    // ****************************************
    // overheat with hysteresis
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overheat <= 1'b0;
        end else if (offReq || !overheatEnable) begin
            overheat <= 1'b0;
        end else if (tempLevel >= fps_pkg::OVERHEAT_THR) begin
            overheat <= 1'b1;
        end else if (tempLevel < fps_pkg::OVERHEAT_REL) begin
            overheat <= 1'b0;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        unique case (next_state)
            fps_pkg::ST_OFF:  next_pwm = 1'b0;
            fps_pkg::ST_RUN:  next_pwm = ctrlLevel > ramp;
            default:          next_pwm = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwmOut <= 1'b0;
        end else begin
            pwmOut <= next_pwm;
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            faultOut <= 1'b0;
            faultOe  <= 1'b0;
        end else begin
            faultOut <= 1'b0;
            faultOe  <= (next_state == fps_pkg::ST_FAULT) ||
                        (overheat && next_state != fps_pkg::ST_OFF);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_off_pwm_low: assert property (state == fps_pkg::ST_OFF |-> !pwmOut)
        else $error("pwm high in shutdown");
    chk_off_alarm_free: assert property (state == fps_pkg::ST_OFF |-> !faultOe)
        else $error("alarm driven in shutdown");
    chk_fault_full_drive: assert property (state == fps_pkg::ST_FAULT |-> pwmOut && faultOe)
        else $error("fault state without full drive and alarm");
    chk_run_compare: assert property (state == fps_pkg::ST_RUN |-> pwmOut == $past(ctrlLevel > ramp))
        else $error("pwm does not follow level versus ramp");
    chk_level_larger: assert property (ctrlLevel >= tempLevel && ctrlLevel >= minSpeedLevel)
        else $error("controlling level not the larger one");
    chk_shutdown_entry: assert property (offReq |=> state == fps_pkg::ST_OFF && !pwmOut)
        else $error("shutdown request not honoured");
    chk_diag_entry: assert property (
        $rose(state == fps_pkg::ST_DIAG) |-> $past(missCnt) == 6'h1f && $past(cycleTick))
        else $error("diagnostic entered at wrong count");
    chk_diag_pulse_ok: assert property (
        state == fps_pkg::ST_DIAG && pulseOk && !offReq |=> state == fps_pkg::ST_RUN)
        else $error("pulse in diagnostic did not resume pwm");
    chk_miss_clear: assert property (state == fps_pkg::ST_RUN && pulseOk |=> missCnt == 6'h00)
        else $error("pulse did not clear missing-pulse count");
    chk_fault_clear: assert property (state == fps_pkg::ST_FAULT && winCnt == 5'h10 && !offReq
        |=> state == fps_pkg::ST_RUN && missCnt == 6'h00 ##1 !faultOe || overheat)
        else $error("fault not cleared after 16 pulses");
    chk_wake_startup: assert property (
        state == fps_pkg::ST_OFF && wakeReq && !offReq |=> state == fps_pkg::ST_STARTUP ##1 pwmOut)
        else $error("wake did not start power-up");
    chk_overheat_set: assert property (
        overheatEnable && !offReq && tempLevel >= 9'h106 |=> overheat)
        else $error("overheat not flagged at threshold");
    chk_overheat_hold: assert property (
        overheat && overheatEnable && !offReq && tempLevel >= 9'h0fe |=> overheat)
        else $error("overheat released inside hysteresis band");
    chk_blank_ignore: assert property (blankCnt != 11'h000 |-> !pulseOk)
        else $error("pulse accepted during blanking");

    cov_fault_reached: cover property (state == fps_pkg::ST_STARTUP ##1 state == fps_pkg::ST_FAULT);
    cov_fault_recover: cover property (state == fps_pkg::ST_FAULT ##1 state == fps_pkg::ST_RUN);
    cov_diag_recover: cover property (state == fps_pkg::ST_DIAG ##1 state == fps_pkg::ST_RUN);
    cov_alarm_seen: cover property (faultOe && !faultIn);

endmodule

// ### bench/fps_fan_model.sv
// fan current sensor and alarm pull-up model at the far side of the supervisor
`timescale 1ns/1ns

module fps_fan_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic spin,
    input  wire logic faultOe,
    input  wire logic faultOut,
    output logic      fanPulse,
    output logic      faultIn
);
    logic [4:0] gapCnt;

    // ****************************************
    // commutation pulses
    // ****************************************
    // one-cycle strobe every 20 clocks, only while the bench says the rotor turns
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gapCnt   <= 5'h00;
            fanPulse <= 1'b0;
        end else begin
            gapCnt   <= (gapCnt == 5'h13) ? 5'h00 : gapCnt + 5'h01;
            fanPulse <= spin && (gapCnt == 5'h13);
        end
    end

    // ****************************************
    // alarm wire
    // ****************************************
    // external pull-up: a released pin reads high
    assign faultIn = faultOe ? faultOut : 1'b1;
endmodule

// ### bench/fps_fan_pwm_fault_supervisor_test.sv
// self-checking bench for the fan pwm fault supervisor
`timescale 1ns/1ns

module fps_fan_pwm_fault_supervisor_test;
    // small ramp step keeps 64-cycle supervision runs short
    localparam int STEP = 5;
    localparam int CYC  = STEP * int'(fps_pkg::RAMP_SPAN);

    logic       sys_clk        = 1'b0;
    logic       rst            = 1'b1;
    logic [8:0] tempLevel      = fps_pkg::RAMP_FLOOR;
    logic [8:0] minSpeedLevel  = fps_pkg::RAMP_FLOOR;
    logic [8:0] offThreshold   = 9'h060;
    logic [8:0] wakeThreshold  = 9'h070;
    logic       overheatEnable = 1'b1;
    logic       spin           = 1'b1;
    logic       fanPulse;
    logic       faultIn;
    logic       pwmOut;
    logic       faultOut;
    logic       faultOe;
    int         miscompares    = 0;
    int         checks_done    = 0;
    int         cycles         = 0;

    fps_fan_pwm_fault_supervisor #(.STEP_CYCLES(STEP)) fps_fan_pwm_fault_supervisor_inst (
        .sys_clk(sys_clk), .rst(rst), .tempLevel(tempLevel), .minSpeedLevel(minSpeedLevel),
        .offThreshold(offThreshold), .wakeThreshold(wakeThreshold), .overheatEnable(overheatEnable),
        .fanPulse(fanPulse), .faultIn(faultIn), .pwmOut(pwmOut), .faultOut(faultOut), .faultOe(faultOe));

    fps_fan_model fps_fan_model_inst (
        .sys_clk(sys_clk), .rst(rst), .spin(spin), .faultOe(faultOe), .faultOut(faultOut),
        .fanPulse(fanPulse), .faultIn(faultIn));

    always #5 sys_clk = ~sys_clk;

    // ****************************************
    // helpers
    // ****************************************
    task automatic close_out();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hang is cut here; full run is about 90k cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 98000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic measure(input int n, output int highs, output int rises);
        logic prev;
        highs = 0;
        rises = 0;
        prev = pwmOut;
        repeat (n) begin
            @(posedge sys_clk);
            if (pwmOut === 1'b1) highs++;
            if (pwmOut === 1'b1 && prev !== 1'b1) rises++;
            prev = pwmOut;
        end
    endtask

    // clocks until a high run begins that lasts longer than one pwm cycle
    task automatic wait_long_high(input int limit, output int startAt);
        int run;
        run = 0;
        startAt = -1;
        for (int n = 0; n < limit && startAt < 0; n++) begin
            @(posedge sys_clk);
            run = (pwmOut === 1'b1) ? run + 1 : 0;
            if (run == CYC + 20) startAt = n - CYC - 19;
        end
    endtask

    task automatic set_levels(input logic [8:0] t, input logic [8:0] m);
        @(posedge sys_clk);
        tempLevel     <= t;
        minSpeedLevel <= m;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_power_up();
        int highs;
        int rises;
        repeat (2) @(posedge sys_clk);
        measure(1800, highs, rises);
        check(32'(highs), 32'd1800);
        measure(600, highs, rises);
        check(32'(highs < 600), 32'h1);
        measure(CYC, highs, rises);
        check(32'(highs), 32'h0);
        $display("test power_up done");
    endtask

    task automatic test_duty();
        logic [8:0] t [4] = '{9'h0b4, 9'h078, 9'h0f0, 9'h104};
        logic [8:0] m [4] = '{9'h078, 9'h0d2, 9'h0a0, 9'h078};
        int highs;
        int rises;
        for (int i = 0; i < 4; i++) begin
            set_levels(t[i], m[i]);
            measure(10, highs, rises);
            measure(2 * CYC, highs, rises);
            check(32'(highs), 32'(2 * STEP * (int'(t[i] > m[i] ? t[i] : m[i]) - 120)));
            check(32'(rises), (i == 3) ? 32'h0 : 32'h2);
        end
        $display("test duty done");
    endtask

    task automatic test_diag();
        int startAt;
        int highs;
        int rises;
        // zero duty: no turn-on blanking, so pulses clear the miss count before the fan stops
        set_levels(fps_pkg::RAMP_FLOOR, fps_pkg::RAMP_FLOOR);
        repeat (3 * CYC) @(posedge sys_clk);
        spin <= 1'b0;
        wait_long_high(40 * CYC, startAt);
        check(32'(startAt >= 31 * CYC - 20 && startAt <= 32 * CYC + 1), 32'h1);
        spin <= 1'b1;
        measure(2000, highs, rises);
        check(32'(highs < 2000), 32'h1);
        check(32'(faultOe), 32'h0);
        $display("test diag done");
    endtask

    task automatic test_fault();
        int startAt;
        int n;
        int lows;
        int highs;
        int rises;
        spin <= 1'b0;
        wait_long_high(40 * CYC, startAt);
        n = 0;
        lows = 0;
        while (faultOe !== 1'b1 && n < 40 * CYC) begin
            @(posedge sys_clk);
            n++;
            if (pwmOut !== 1'b1) lows++;
        end
        check(32'(lows), 32'h0);
        check(32'(n + CYC + 20 >= 34 * CYC && n + CYC + 20 <= 36 * CYC), 32'h1);
        check(32'(faultIn), 32'h0);
        set_levels(fps_pkg::RAMP_FLOOR, 9'h0a0);
        measure(3 * CYC, highs, rises);
        check(32'(highs), 32'(3 * CYC));
        check(32'(faultOe), 32'h1);
        spin <= 1'b1;
        n = 0;
        while (faultOe === 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        check(32'(n >= 300 && n <= 1000), 32'h1);
        measure(10, highs, rises);
        measure(2 * CYC, highs, rises);
        check(32'(highs), 32'(2 * STEP * 40));
        $display("test fault done");
    endtask

    task automatic test_overheat();
        logic [8:0] t [5] = '{fps_pkg::OVERHEAT_THR - 9'h001, fps_pkg::OVERHEAT_THR, fps_pkg::OVERHEAT_REL,
                              fps_pkg::OVERHEAT_REL - 9'h001, fps_pkg::OVERHEAT_THR};
        logic       e [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        logic       x [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 5; i++) begin
            set_levels(t[i], 9'h0a0);
            overheatEnable <= e[i];
            repeat (3) @(posedge sys_clk);
            check(32'(faultOe), 32'(x[i]));
        end
        overheatEnable <= 1'b1;
        $display("test overheat done");
    endtask

    task automatic test_shutdown();
        int highs;
        int rises;
        set_levels(9'h0b4, 9'h050);
        repeat (2) @(posedge sys_clk);
        measure(2 * CYC, highs, rises);
        check(32'(highs), 32'h0);
        check(32'(faultOe), 32'h0);
        set_levels(9'h0b4, 9'h0a0);
        repeat (2) @(posedge sys_clk);
        measure(1800, highs, rises);
        check(32'(highs), 32'd1800);
        $display("test shutdown done");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        test_power_up();
        test_duty();
        test_diag();
        test_fault();
        test_overheat();
        test_shutdown();
        close_out();
    end
endmodule
